// [design/staging_cfg.svh]
// constants for the auxiliary motor staging controller: offsets, fields, resets, timing
// assumes byte addressing on a 32-bit register bus, frequencies in 0.1 Hz, steps in 0.1 %
// Summary of operation
// RULE1: one or more helpers running adds reference step one to process target
// RULE2: two or more helpers running also adds reference step two
// RULE3: three helpers running also adds reference step three
// RULE4: all three reference steps reset to zero percent
// RULE5: none running and output above on-threshold one plus 1 Hz arms start delay
// RULE6: start delay expiry starts next helper only if output above threshold minus 1 Hz
// RULE7: after first start, lower output by on-threshold one minus off-threshold one
// RULE8: one running and output above on-threshold two plus 1 Hz arms start delay
// RULE9: after second start, lower output by on-threshold two minus off-threshold two
// RULE10: two running, above on-threshold three plus 1 Hz, confirmed: start third, lower output
// RULE11: one running, below off-threshold one minus 1 Hz arms stop delay; stop if still low
// RULE12: after stopping first helper, raise output by threshold one difference
// RULE13: software keeps each on-threshold between its off-threshold and upper limit less one
// RULE14: software keeps off-threshold one between lower limit plus one and on-threshold one
// RULE15: two running, stop second after stop delay below off-threshold two, raise output
// RULE16: one shared start delay setting serves every start decision
// RULE17: one shared stop delay setting serves every stop decision
// RULE18: never run more helpers than the configured helper count
// RULE19: delays count a fixed tick; counter clears when its trigger vanishes before expiry
`ifndef STAGING_CFG_SVH
`define STAGING_CFG_SVH
`define CTRL_OFS        8'h00
`define ON_THR_OFS      8'h04
`define OFF_THR_OFS     8'h10
`define ON_DELAY_OFS    8'h1c
`define OFF_DELAY_OFS   8'h20
`define REF_STEP_OFS    8'h24
`define STATUS_OFS      8'h30
`define FREQ_OFS        8'h34
`define CTRL_EN_BIT     0
`define CTRL_CNT_LSB    1
`define CTRL_RST        3'h7
`define ON_THR_RST      16'h01f4
`define OFF_THR_RST     16'h0190
`define DELAY_RST       16'h0032
`define REF_STEP_RST    16'h0000
`define HYST            17'h0000a
`define MAX_HELPERS     2'h3
`define CLK_PERIOD_NS   10
`define TICK_NS         100000000
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// [design/staging_pkg.sv]
// types shared by the staging controller, its monitor and the regulator model
// assumes staging_cfg.svh for the numbers
package staging_pkg;
	typedef logic [15:0] freq_t;
	typedef logic [1:0]  motor_count_t;
	typedef enum {act_none, act_start, act_stop, act_trim} stage_act_t;
endpackage

// [design/staging_if.sv]
// link between the staging controller and one delay counter
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface staging_if;
	logic        ce;
	logic        tick;
	logic        arm;
	logic        clr;
	logic [15:0] limit;
	logic        expired;
	modport ctl (output ce, output tick, output arm, output clr, output limit, input expired);
	modport tmr (input ce, input tick, input arm, input clr, input limit, output expired);
endinterface
`default_nettype wire

// [design/delay_timer.sv]
// delay counter in timebase ticks, cleared whenever its trigger drops
// assumes arm is evaluated every cycle by the owner
`timescale 1ns/1ps
`default_nettype none
module delay_timer (
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	staging_if.tmr    dly
);
	logic [15:0] count;

	// trigger loss before expiry discards the partial count
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			count <= 16'h0000;
		else if (dly.ce)
		begin
			if (!dly.arm || dly.clr)
				count <= 16'h0000; // RULE19
			else if (dly.tick && count < dly.limit)
				count <= count + 16'h0001; // RULE19
		end
	end

	// a limit of zero expires as soon as the trigger appears
	assign dly.expired = dly.arm && (count >= dly.limit);
endmodule // delay_timer
`default_nettype wire

// [design/aux_motor_staging_control.sv]
// staging controller: adds and removes up to three constant-speed helper motors
// assumes output frequency from the speed regulator, AXI4-Lite register access, one clock
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "staging_cfg.svh"
module aux_motor_staging_control
	import staging_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire freq_t       output_freq_i,
	input  wire logic [15:0] internal_process_target_i,
	output logic [15:0]      process_target_o,
	output logic [2:0]       helper_run_o,
	output logic [16:0]      freq_shift_o,
	output logic             freq_shift_valid_o
);
	// configuration
	logic         enable;
	motor_count_t helper_motor_count;
	freq_t        on_thr [3];
	freq_t        off_thr [3];
	logic [15:0]  staging_on_delay;
	logic [15:0]  staging_off_delay;
	logic [15:0]  ref_step [3];

	// bus state
	logic         aw_held;
	logic         w_held;
	logic [7:0]   aw_addr;
	logic [31:0]  w_data;
	logic [3:0]   w_strb;
	logic         do_write;
	logic [31:0]  rd_data;
	logic         rd_ok;
	logic         wr_ok;

	// staging state
	motor_count_t running;
	logic [31:0]  tick_cnt;
	logic         tick;
	motor_count_t up_idx;
	motor_count_t dn_idx;
	logic [16:0]  freq17;
	logic [16:0]  on17;
	logic [16:0]  off17;
	logic         can_add;
	logic         start_ok;
	logic         stop_ok;
	stage_act_t   act;
	logic [15:0]  step_used [3];
	logic [17:0]  next_target;

	staging_if start_dly ();
	staging_if stop_dly ();

	// keep only the addressed byte lanes of a 16-bit field
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// write side: address and data may arrive in either order
	assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
	assign do_write        = aw_held && w_held;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
		end
		else if (ce_i)
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
			end
		end
	end

	// status and frequency words are read-only but writing them is not an error
	always_comb
	begin
		wr_ok = (aw_addr[7:2] <= `FREQ_OFS >> 2) && (aw_addr[1:0] == 2'h0);
	end

	// write response follows the cycle in which both halves are held
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `RESP_OKAY;
		end
		else if (ce_i)
		begin
			if (do_write)
			begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			{helper_motor_count, enable} <= `CTRL_RST;
			staging_on_delay  <= `DELAY_RST;
			staging_off_delay <= `DELAY_RST;
			for (int i = 0; i < 3; i++)
			begin
				on_thr[i]   <= `ON_THR_RST;
				off_thr[i]  <= `OFF_THR_RST;
				ref_step[i] <= `REF_STEP_RST; // RULE4
			end
		end
		else if (ce_i && do_write)
		begin
			if (aw_addr == `CTRL_OFS && w_strb[0])
			begin
				enable             <= w_data[`CTRL_EN_BIT];
				helper_motor_count <= w_data[`CTRL_CNT_LSB +: 2];
			end
			if (aw_addr == `ON_DELAY_OFS)
				staging_on_delay <= merge16(staging_on_delay, w_data, w_strb); // RULE16
			if (aw_addr == `OFF_DELAY_OFS)
				staging_off_delay <= merge16(staging_off_delay, w_data, w_strb); // RULE17
			for (int i = 0; i < 3; i++)
			begin
				if (aw_addr == 8'(`ON_THR_OFS + 4 * i))
					on_thr[i] <= merge16(on_thr[i], w_data, w_strb);
				if (aw_addr == 8'(`OFF_THR_OFS + 4 * i))
					off_thr[i] <= merge16(off_thr[i], w_data, w_strb);
				if (aw_addr == 8'(`REF_STEP_OFS + 4 * i))
					ref_step[i] <= merge16(ref_step[i], w_data, w_strb);
			end
		end
	end

	// read multiplexer, unmapped words answer with an error
	always_comb
	begin
		rd_data = 32'h00000000;
		rd_ok   = 1'b1;
		case (s_axi_araddr_i)
			`CTRL_OFS:      rd_data = {29'h0, helper_motor_count, enable};
			`ON_DELAY_OFS:  rd_data = {16'h0, staging_on_delay};
			`OFF_DELAY_OFS: rd_data = {16'h0, staging_off_delay};
			`STATUS_OFS:    rd_data = {26'h0, stop_dly.arm, start_dly.arm, 2'h0, running};
			`FREQ_OFS:      rd_data = {16'h0, output_freq_i};
			default:
			begin
				rd_ok = 1'b0;
				for (int i = 0; i < 3; i++)
				begin
					if (s_axi_araddr_i == 8'(`ON_THR_OFS + 4 * i))
					begin
						rd_data = {16'h0, on_thr[i]};
						rd_ok   = 1'b1;
					end
					if (s_axi_araddr_i == 8'(`OFF_THR_OFS + 4 * i))
					begin
						rd_data = {16'h0, off_thr[i]};
						rd_ok   = 1'b1;
					end
					if (s_axi_araddr_i == 8'(`REF_STEP_OFS + 4 * i))
					begin
						rd_data = {16'h0, ref_step[i]};
						rd_ok   = 1'b1;
					end
				end
			end
		endcase
	end

	// read answer one cycle after the address is taken
	assign s_axi_arready_o = !s_axi_rvalid_o;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h00000000;
			s_axi_rresp_o  <= `RESP_OKAY;
		end
		else if (ce_i)
		begin
			if (s_axi_arvalid_i && s_axi_arready_o)
			begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o  <= rd_data;
				s_axi_rresp_o  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_rready_i)
				s_axi_rvalid_o <= 1'b0;
		end
	end

	// timebase tick for both delay counters
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			tick_cnt <= 32'h00000000;
		else if (ce_i)
			tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
	end

	assign tick = (tick_cnt >= TICK_CYCLES - 1); // RULE19

	// thresholds of the next helper to add and the last helper to drop
	always_comb
	begin
		up_idx  = (running == `MAX_HELPERS) ? 2'h2 : running;
		dn_idx  = (running == 2'h0) ? 2'h0 : running - 2'h1;
		freq17  = {1'b0, output_freq_i};
		on17    = {1'b0, on_thr[up_idx]};
		off17   = {1'b0, off_thr[dn_idx]};
		can_add = enable && running < helper_motor_count && running < `MAX_HELPERS; // RULE18
	end

	// start arms above threshold plus hysteresis, stop arms below low threshold minus it
	assign start_dly.ce    = ce_i;
	assign start_dly.tick  = tick;
	assign start_dly.limit = staging_on_delay; // RULE16
	assign start_dly.arm   = can_add && (freq17 > on17 + `HYST); // RULE5 RULE8 RULE10
	assign start_dly.clr   = (act != act_none);
	assign stop_dly.ce     = ce_i;
	assign stop_dly.tick   = tick;
	assign stop_dly.limit  = staging_off_delay; // RULE17
	assign stop_dly.arm    = enable && running != 2'h0 && (freq17 + `HYST < off17); // RULE11 RULE15
	assign stop_dly.clr    = (act != act_none);
	assign start_ok        = freq17 + `HYST > on17; // RULE6
	assign stop_ok         = freq17 < off17 + `HYST; // RULE11

	delay_timer u_start_dly (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.dly       (start_dly.tmr)
	);

	delay_timer u_stop_dly (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.dly       (stop_dly.tmr)
	);

	// trimming to the configured count outranks any timed decision
	always_comb
	begin
		if (running > helper_motor_count || (!enable && running != 2'h0))
			act = act_trim; // RULE18
		else if (start_dly.expired && start_ok)
			act = act_start; // RULE6
		else if (stop_dly.expired && stop_ok)
			act = act_stop; // RULE11 RULE15
		else
			act = act_none;
	end

	// helper count and the frequency correction that follows each start or stop
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			running            <= 2'h0;
			freq_shift_o       <= 17'h00000;
			freq_shift_valid_o <= 1'b0;
		end
		else if (ce_i)
		begin
			freq_shift_valid_o <= 1'b0;
			case (act)
				act_start:
				begin
					running            <= running + 2'h1;
					freq_shift_o       <= off17 - on17 + {1'b0, off_thr[up_idx]} - off17; // RULE7 RULE9 RULE10
					freq_shift_valid_o <= 1'b1;
				end
				act_stop:
				begin
					running            <= running - 2'h1;
					freq_shift_o       <= {1'b0, on_thr[dn_idx]} - off17; // RULE12 RULE15
					freq_shift_valid_o <= 1'b1;
				end
				act_trim:
					running <= enable ? helper_motor_count : 2'h0; // no step: not a regulated switch
				act_none:
					running <= running;
				default:
					running <= running;
			endcase
		end
	end

	// cumulative reference steps per running helper
	for (genvar i = 0; i < 3; i++)
	begin : g_step
		assign step_used[i] = (running > 2'(i)) ? ref_step[i] : 16'h0000; // RULE1 RULE2 RULE3
		always_ff @(posedge clk_sys_i)
		begin
			if (rst_i)
				helper_run_o[i] <= 1'b0;
			else if (ce_i)
				helper_run_o[i] <= (act == act_start) ? (running >= 2'(i)) :
					(act == act_stop) ? (running > 2'(i + 1)) :
					(act == act_trim) ? ((enable ? helper_motor_count : 2'h0) > 2'(i)) :
					(running > 2'(i));
		end
	end

	assign next_target = {2'h0, internal_process_target_i} + {2'h0, step_used[0]}
		+ {2'h0, step_used[1]} + {2'h0, step_used[2]};

	// saturate rather than wrap when steps push the target past full scale
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			process_target_o <= 16'h0000;
		else if (ce_i)
			process_target_o <= (next_target[17:16] != 2'h0) ? 16'hffff : next_target[15:0];
	end
endmodule // aux_motor_staging_control
`default_nettype wire

// [tb/staging_monitor.sv]
// checker on the staging controller ports: shifts, run steps, target sums
// assumes bound into aux_motor_staging_control, one clock domain
`timescale 1ns/1ps
`default_nettype none
module staging_monitor
	import staging_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic [15:0] internal_process_target_i,
	input  wire logic [15:0] process_target_o,
	input  wire logic [2:0]  helper_run_o,
	input  wire logic [16:0] freq_shift_o,
	input  wire logic        freq_shift_valid_o
);
	// frozen cycles say nothing about timing, so they are skipped
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i || !ce_i);

	property p_up_neg;
		freq_shift_valid_o && helper_run_o > $past(helper_run_o) |-> freq_shift_o[16] || freq_shift_o == 17'h0;
	endproperty
	a_up_neg: assert property (p_up_neg) else $error("start without downward shift");
	property p_dn_pos;
		freq_shift_valid_o && helper_run_o < $past(helper_run_o) |-> !freq_shift_o[16];
	endproperty
	a_dn_pos: assert property (p_dn_pos) else $error("stop without upward shift");
	property p_pulse_one;
		freq_shift_valid_o |=> !freq_shift_valid_o;
	endproperty
	a_pulse_one: assert property (p_pulse_one) else $error("shift pulse too long");
	property p_pulse_moves;
		freq_shift_valid_o |-> $countones(helper_run_o ^ $past(helper_run_o)) == 1;
	endproperty
	a_pulse_moves: assert property (p_pulse_moves) else $error("shift pulse without one step");
	property p_up_pulsed;
		helper_run_o > $past(helper_run_o) |-> freq_shift_valid_o;
	endproperty
	a_up_pulsed: assert property (p_up_pulsed) else $error("helper added silently");
	property p_hold_shift;
		!freq_shift_valid_o && !$past(rst_i) |-> $stable(freq_shift_o);
	endproperty
	a_hold_shift: assert property (p_hold_shift) else $error("shift moved without pulse");
	property p_target_idle;
		!$past(rst_i) && $past(ce_i) && $past(helper_run_o) == 3'h0
			|-> process_target_o == $past(internal_process_target_i);
	endproperty
	a_target_idle: assert property (p_target_idle) else $error("target offset while idle");
	property p_target_ge;
		!$past(rst_i) && $past(ce_i) |-> process_target_o >= $past(internal_process_target_i);
	endproperty
	a_target_ge: assert property (p_target_ge) else $error("target below reference");
	property p_thermo;
		helper_run_o inside {3'h0, 3'h1, 3'h3, 3'h7};
	endproperty
	a_thermo: assert property (p_thermo) else $error("run pattern broken");

	c_start: cover property (freq_shift_valid_o && freq_shift_o[16]);
	c_stop: cover property (freq_shift_valid_o && !freq_shift_o[16]);
	c_full: cover property (helper_run_o == 3'h7);
endmodule // staging_monitor

bind aux_motor_staging_control staging_monitor staging_monitor_i (
	.clk_sys_i,
	.rst_i,
	.ce_i,
	.internal_process_target_i,
	.process_target_o,
	.helper_run_o,
	.freq_shift_o,
	.freq_shift_valid_o
);
`default_nettype wire

// [tb/speed_regulator_model.sv]
// speed regulator: output frequency follows demand, then staging corrections
// assumes load from the bench and shift pulses from the controller
`timescale 1ns/1ps
`default_nettype none
module speed_regulator_model
	import staging_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        load_i,
	input  wire freq_t       demand_i,
	input  wire logic        shift_valid_i,
	input  wire logic [16:0] shift_i,
	output freq_t            freq_o
);
	// load wins; wraps like the real 16-bit frequency word
	always_ff @(posedge clk_sys_i)
	begin
		if (load_i)
			freq_o <= demand_i;
		else if (shift_valid_i)
			freq_o <= freq_o + shift_i[15:0];
	end
endmodule // speed_regulator_model
`default_nettype wire

// [tb/aux_motor_staging_control_test.sv]
// bench: register bus tasks, then staging up through all helpers, a trim to two, and staging down
// assumes short tick parameter and the regulator model on the frequency path
`timescale 1ns/1ps
`default_nettype none
`include "staging_cfg.svh"
module aux_motor_staging_control_test;
	import staging_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic        ce_i      = 1'b1;
	logic [7:0]  awaddr    = 8'h00;
	logic        awvalid   = 1'b0;
	logic [31:0] wdata     = 32'h0;
	logic        wvalid    = 1'b0;
	logic        bready    = 1'b0;
	logic [7:0]  araddr    = 8'h00;
	logic        arvalid   = 1'b0;
	logic        rready    = 1'b0;
	logic        load      = 1'b1;
	freq_t       demand    = 16'h0000;
	logic [15:0] target    = 16'h0100;
	logic        awready, wready, bvalid, arready, rvalid, pulse;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	freq_t       freq;
	logic [15:0] ptgt;
	logic [2:0]  run;
	logic [16:0] shift;
	int          num_errors   = 0;
	int          total_checks = 0;
	// settings kept inside the advised threshold ordering
	localparam logic [7:0] cfg_a [9] = '{`ON_DELAY_OFS, `OFF_DELAY_OFS, `ON_THR_OFS + 8'h04, `ON_THR_OFS + 8'h08,
		`OFF_THR_OFS + 8'h04, `OFF_THR_OFS + 8'h08, `REF_STEP_OFS, `REF_STEP_OFS + 8'h04, `REF_STEP_OFS + 8'h08};
	localparam logic [31:0] cfg_d [9] = '{32'h2, 32'h2, 32'h258, 32'h2bc, 32'h1c2, 32'h1f4, 32'ha, 32'h14, 32'h1e};
	localparam logic [15:0] st_f [5] = '{16'h0208, 16'h026c, 16'h02d0, 16'h01ae, 16'h017c};
	localparam logic [2:0] st_run [5] = '{3'h1, 3'h3, 3'h7, 3'h1, 3'h0};
	localparam logic [16:0] st_sh [5] = '{17'h1ff9c, 17'h1ff6a, 17'h1ff38, 17'h00096, 17'h00064};
	localparam logic [15:0] st_tg [5] = '{16'h000a, 16'h001e, 16'h003c, 16'h000a, 16'h0000};

	initial forever #5 clk_sys_i = ~clk_sys_i;

	aux_motor_staging_control #(.TICK_CYCLES(2)) aux_motor_staging_control_i (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.output_freq_i(freq), .internal_process_target_i(target), .process_target_o(ptgt),
		.helper_run_o(run), .freq_shift_o(shift), .freq_shift_valid_o(pulse)
	);
	speed_regulator_model speed_regulator_model_i (
		.clk_sys_i(clk_sys_i), .load_i(load), .demand_i(demand),
		.shift_valid_i(pulse), .shift_i(shift), .freq_o(freq)
	);

	task wrap_up;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task give_up;
		num_errors++;
		$display("[FAIL] %0t wait ran out", $time);
		wrap_up();
	endtask
	// both halves offered together, each dropped when its ready is seen
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		// one edge between calls so bready is never lowered and raised in one step
		@(posedge clk_sys_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++)
		begin
			@(posedge clk_sys_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		r = bresp;
		if (n == 64) give_up();
	endtask
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk_sys_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64; n++)
		begin
			@(posedge clk_sys_i);
			if (arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		if (n == 64) give_up();
	endtask
	task set_freq(input logic [15:0] v);
		demand <= v;
		load <= 1'b1;
		@(posedge clk_sys_i);
		load <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task wait_pulse;
		int n;
		for (n = 0; n < 400; n++)
		begin
			@(posedge clk_sys_i);
			if (pulse === 1'b1) break;
		end
		if (n == 400) give_up();
	endtask

	initial
	begin
		logic [1:0]  r;
		logic [31:0] d;
		int          i;
		repeat (20) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		load <= 1'b0;
		axi_rd(`REF_STEP_OFS, d, r);
		chk(d, 32'h0);
		axi_rd(`CTRL_OFS, d, r);
		chk(d, 32'h7);
		for (i = 0; i < 9; i++)
		begin
			axi_wr(cfg_a[i], cfg_d[i], r);
			chk(r, `RESP_OKAY);
		end
		axi_rd(`REF_STEP_OFS + 8'h04, d, r);
		chk(d, 32'h14);
		axi_wr(8'h40, 32'h1, r);
		chk(r, `RESP_SLVERR);
		axi_rd(8'h40, d, r);
		chk(r, `RESP_SLVERR);
		// two-cycle excursion above the start level must not stage
		set_freq(16'h0208);
		set_freq(16'h01e0);
		repeat (30) @(posedge clk_sys_i);
		chk(run, 3'h0);
		for (i = 0; i < 5; i++)
		begin
			if (i == 3)
			begin
				axi_wr(`CTRL_OFS, 32'h5, r);
				repeat (3) @(posedge clk_sys_i);
				chk(run, 3'h3);
				chk(ptgt, 16'h011e);
			end
			set_freq(st_f[i]);
			wait_pulse();
			chk(run, st_run[i]);
			chk(shift, st_sh[i]);
			repeat (2) @(posedge clk_sys_i);
			chk(ptgt, 16'h0100 + st_tg[i]);
		end
		// idle status and frequency readback
		axi_rd(`STATUS_OFS, d, r);
		chk(d, 32'h0);
		axi_rd(`FREQ_OFS, d, r);
		chk(d, 32'h1e0);
		// frozen clock enable must hold off staging
		ce_i <= 1'b0;
		set_freq(16'h0208);
		repeat (20) @(posedge clk_sys_i);
		chk(run, 3'h0);
		ce_i <= 1'b1;
		wait_pulse();
		chk(run, 3'h1);
		chk(shift, 17'h1ff9c);
		wrap_up();
	end
endmodule // aux_motor_staging_control_test
`default_nettype wire
